// ---- rtl/sfr_page_stack_control.v ----
`timescale 1ns/1ns
`include "sfr_page_map.vh"
// Notes on behaviour
// - Direct accesses at 0x80..0xff are special register accesses on active page.
// - Low nibble 0 or 8 allows bit access; others byte only.
// - Up to 256 pages overlay one range; pages 0 and 15 populated.
// - Five byte stack: page select on top, four saved levels below.
// - Readout returns stack entry picked by index; 0 is top, 4 bottom.
// - Interrupt entry with auto paging shifts levels down, page into level 1.
// - After push, page select loads the serviced source's flag page.
// - Return restores level 1 to page select and shifts levels up.
// - Auto paging enable bit resets to one, stays until software clears.
// - Software page writes work unless a push or pop wins that cycle, and never touch saved levels.
// - Push only on interrupt service, pop only on return; nesting pushes again.
// - Page select is 8-bit read/write on all pages, resets to zero.
// - Page control on all pages: index bits 6..4, enable bit 0 = 1.
// - Readout is read-only on page fifteen, resets zero, shows indexed level.
module sfr_page_stack_control #(
  parameter PAGE_W = 8
) (
  // Clock and reset
  input  wire              core_clk_i,
  input  wire              reset_n_i,
  // Direct access from the core
  input  wire              dir_valid_i,
  input  wire              dir_write_i,
  input  wire              dir_bit_i,
  input  wire [2:0]        dir_bit_sel_i,
  input  wire [7:0]        dir_addr_i,
  input  wire [7:0]        dir_wdata_i,
  output reg  [7:0]        dir_rdata_o,
  output wire              dir_hit_o,
  output wire              sfr_sel_o,
  output wire              bit_ok_o,
  // Interrupt vectoring
  input  wire              irq_enter_i,
  input  wire [PAGE_W-1:0] irq_page_i,
  input  wire              irq_return_i,
  // Page state
  output wire [PAGE_W-1:0] active_page_o,
  output wire              auto_paging_enable_o
);

  // Architectural registers
  reg  [PAGE_W-1:0] active_page_select;
  reg  [7:0]        page_control_reg;
  reg  [7:0]        stack_readout_reg;

  // Next values
  reg  [PAGE_W-1:0] next_active_page;
  reg  [7:0]        next_page_control;
  reg  [7:0]        next_rdata;

  // Stack levels and control fields
  wire [PAGE_W-1:0] level [0:`STACK_LEVELS-1];
  wire [2:0]        stack_level_index;
  wire              auto_paging_enable;
  wire              push;
  wire              pop;

  // Address decode
  wire              bit_addr;
  wire              acc_ok;
  wire              on_page_f;
  wire              hit_page;
  wire              hit_ctrl;
  wire              hit_stack;

  // Write path
  wire              wr_page;
  wire              wr_ctrl;
  wire [7:0]        bit_mask;
  wire [7:0]        page_merge;
  wire [7:0]        ctrl_merge;

  // Decode of the special register window
  assign sfr_sel_o = dir_valid_i && (dir_addr_i >= `SFR_SPACE_LO);
  assign bit_addr  = (dir_addr_i[3:0] == `SFR_BIT_NIB_A) ||
                     (dir_addr_i[3:0] == `SFR_BIT_NIB_B);
  assign bit_ok_o  = sfr_sel_o && bit_addr;
  assign on_page_f = (active_page_select == `PAGE_FIFTEEN);
  // Bit access only honoured at bit-capable addresses
  assign acc_ok    = sfr_sel_o && (!dir_bit_i || bit_addr);
  assign hit_page  = acc_ok && (dir_addr_i == `ADDR_ACTIVE_PAGE);
  assign hit_ctrl  = acc_ok && (dir_addr_i == `ADDR_PAGE_CONTROL);
  assign hit_stack = acc_ok && on_page_f && (dir_addr_i == `ADDR_STACK_READOUT);
  assign dir_hit_o = hit_page || hit_ctrl || hit_stack;

  // Bit writes merge one bit into the current byte
  assign bit_mask   = `BIT_LSB_MASK << dir_bit_sel_i;
  assign page_merge = dir_bit_i ? ((active_page_select & ~bit_mask) |
                                   ({8{dir_wdata_i[0]}} & bit_mask)) : dir_wdata_i;
  assign ctrl_merge = dir_bit_i ? ((page_control_reg & ~bit_mask) |
                                   ({8{dir_wdata_i[0]}} & bit_mask)) : dir_wdata_i;
  assign wr_page    = hit_page && dir_write_i;
  assign wr_ctrl    = hit_ctrl && dir_write_i;

  // Control fields
  assign stack_level_index  = page_control_reg[`CTRL_IDX_HI:`CTRL_IDX_LO];
  assign auto_paging_enable = page_control_reg[`CTRL_EN_BIT];

  // Stack moves only on service or return, and only with auto paging on
  assign push = irq_enter_i && auto_paging_enable;
  assign pop  = irq_return_i && !irq_enter_i && auto_paging_enable;

  // Next control value: software write only, reserved bits held at zero
  always @* begin
    next_page_control = page_control_reg;
    if (wr_ctrl) begin
      next_page_control = ctrl_merge & `CTRL_WRITE_MASK;
    end
  end

  // Page control register
  always @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      page_control_reg <= `RST_PAGE_CONTROL;
    end else begin
      page_control_reg <= next_page_control;
    end
  end

  // Next top of stack: push beats pop, both beat a software write
  always @* begin
    next_active_page = active_page_select;
    if (push) begin
      next_active_page = irq_page_i;
    end else if (pop) begin
      next_active_page = level[1];
    end else if (wr_page) begin
      next_active_page = page_merge[PAGE_W-1:0];
    end
  end

  // Top of stack: the active page select register
  always @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      active_page_select <= `RST_ACTIVE_PAGE;
    end else begin
      active_page_select <= next_active_page;
    end
  end

  assign level[0] = active_page_select;

  // Saved levels 1..4; the bottom pops in zero
  genvar g;
  generate
    for (g = 1; g < `STACK_LEVELS; g = g + 1) begin : g_lvl
      wire [PAGE_W-1:0] below;
      if (g == `STACK_LEVELS - 1) begin : g_bot
        assign below = `RST_STACK_ENTRY;
      end else begin : g_mid
        assign below = level[g+1];
      end
      stack_level #(
        .WIDTH (PAGE_W)
      ) u_level (
        .core_clk_i (core_clk_i),
        .reset_n_i  (reset_n_i),
        .push_i     (push),
        .pop_i      (pop),
        .above_i    (level[g-1]),
        .below_i    (below),
        .value_o    (level[g])
      );
    end
  endgenerate

  // Readout of the indexed level; invalid index reads zero
  always @* begin
    case (stack_level_index)
      `IDX_LEVEL0: begin
        stack_readout_reg = level[0];
      end
      `IDX_LEVEL1: begin
        stack_readout_reg = level[1];
      end
      `IDX_LEVEL2: begin
        stack_readout_reg = level[2];
      end
      `IDX_LEVEL3: begin
        stack_readout_reg = level[3];
      end
      `STACK_IDX_MAX: begin
        stack_readout_reg = level[4];
      end
      default: begin
        stack_readout_reg = `RST_STACK_ENTRY;
      end
    endcase
  end

  // Read data chosen from the register that the access hits
  always @* begin
    next_rdata = dir_rdata_o;
    if (dir_valid_i && !dir_write_i) begin
      if (hit_page) begin
        next_rdata = active_page_select;
      end else if (hit_ctrl) begin
        next_rdata = page_control_reg;
      end else if (hit_stack) begin
        next_rdata = stack_readout_reg;
      end else begin
        next_rdata = `RST_READ_DATA; // Unoccupied
      end
    end
  end

  // Registered read data, held until the next read
  always @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      dir_rdata_o <= `RST_READ_DATA;
    end else begin
      dir_rdata_o <= next_rdata;
    end
  end

  assign active_page_o        = active_page_select;
  assign auto_paging_enable_o = auto_paging_enable;

endmodule // sfr_page_stack_control

// ---- rtl/sfr_page_map.vh ----
`ifndef SFR_PAGE_MAP_VH
`define SFR_PAGE_MAP_VH
// Direct-access window bounds
`define SFR_SPACE_LO       8'h80
`define SFR_BIT_NIB_A      4'h0
`define SFR_BIT_NIB_B      4'h8
// Register offsets
`define ADDR_ACTIVE_PAGE   8'ha7
`define ADDR_PAGE_CONTROL  8'hcf
`define ADDR_STACK_READOUT 8'hd3
// Populated pages
`define PAGE_ZERO          8'h00
`define PAGE_FIFTEEN       8'h0f
// Page control fields
`define CTRL_IDX_HI        6
`define CTRL_IDX_LO        4
`define CTRL_EN_BIT        0
`define CTRL_WRITE_MASK    8'h71
// Reset values
`define RST_ACTIVE_PAGE    8'h00
`define RST_PAGE_CONTROL   8'h01
`define RST_STACK_ENTRY    8'h00
`define RST_READ_DATA      8'h00
// Single-bit write mask seed
`define BIT_LSB_MASK       8'h01
// Stack level index codes
`define IDX_LEVEL0         3'h0
`define IDX_LEVEL1         3'h1
`define IDX_LEVEL2         3'h2
`define IDX_LEVEL3         3'h3
// Stack geometry
`define STACK_LEVELS       5
`define STACK_IDX_MAX      3'h4
`endif

// ---- rtl/stack_level.v ----
`timescale 1ns/1ns
// One saved page level: loads on push from the level above, on pop from below
module stack_level #(
  parameter WIDTH = 8
) (
  // Clock and reset
  input  wire             core_clk_i,
  input  wire             reset_n_i,
  // Shift control
  input  wire             push_i,
  input  wire             pop_i,
  input  wire [WIDTH-1:0] above_i,
  input  wire [WIDTH-1:0] below_i,
  // Stored value
  output reg  [WIDTH-1:0] value_o
);

  // Shift register stage
  always @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      value_o <= {WIDTH{1'b0}};
    end else if (push_i) begin
      value_o <= above_i;
    end else if (pop_i) begin
      value_o <= below_i;
    end
  end

endmodule // stack_level

// ---- tb/sfr_page_stack_control_asserts.sv ----
`timescale 1ns/1ns
module sfr_page_stack_control_asserts (
  // Clock, reset and core access
  input wire core_clk_i, reset_n_i, dir_valid_i, dir_write_i, dir_bit_i,
  input wire [7:0] dir_addr_i, dir_wdata_i, irq_page_i, active_page_o,
  // Decode and paging outputs, vectoring strobes
  input wire sfr_sel_o, bit_ok_o, irq_enter_i, irq_return_i, auto_paging_enable_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!reset_n_i);
  // Byte write to page select, write to control
  wire pw = dir_valid_i && dir_write_i && !dir_bit_i && dir_addr_i == 8'ha7;
  wire cw = dir_valid_i && dir_write_i && dir_addr_i == 8'hcf;
  wire en = auto_paging_enable_o;
  sequence s_push; irq_enter_i && en; endsequence
  sequence s_pop; irq_return_i && !irq_enter_i && en; endsequence
  a_sel_decode: assert property (sfr_sel_o == (dir_valid_i && dir_addr_i[7]))
    else $error("select decode wrong");
  a_bit_nibble: assert property (bit_ok_o == (sfr_sel_o && dir_addr_i[2:0] == 3'h0))
    else $error("bit capability wrong");
  a_page_write: assert property (pw && !irq_enter_i && !irq_return_i
    |=> active_page_o == $past(dir_wdata_i)) else $error("page write lost");
  a_push_load: assert property (s_push |=> active_page_o == $past(irq_page_i))
    else $error("entry page wrong");
  a_pop_restore: assert property (s_push ##1 s_pop
    |=> active_page_o == $past(active_page_o, 2)) else $error("return page wrong");
  a_auto_off: assert property (!en && !dir_valid_i && (irq_enter_i || irq_return_i)
    |=> $stable(active_page_o)) else $error("page moved while off");
  a_enable_hold: assert property (!cw |=> $stable(en)) else $error("enable moved");
  a_page_quiet: assert property (!pw && !irq_enter_i && !irq_return_i
    |=> $stable(active_page_o)) else $error("page moved unasked");
endmodule // sfr_page_stack_control_asserts
bind sfr_page_stack_control sfr_page_stack_control_asserts chk (.core_clk_i(core_clk_i),
  .reset_n_i(reset_n_i), .dir_valid_i(dir_valid_i), .dir_write_i(dir_write_i),
  .dir_bit_i(dir_bit_i), .dir_addr_i(dir_addr_i), .dir_wdata_i(dir_wdata_i),
  .irq_page_i(irq_page_i), .active_page_o(active_page_o), .sfr_sel_o(sfr_sel_o),
  .bit_ok_o(bit_ok_o), .irq_enter_i(irq_enter_i), .irq_return_i(irq_return_i),
  .auto_paging_enable_o(auto_paging_enable_o));

// ---- tb/core_irq_model.sv ----
`timescale 1ns/1ns
module core_irq_model (
  // Clock, reset and bench requests
  input  wire core_clk_i, reset_n_i, enter_req_i, return_req_i,
  // Vectoring strobes to the block
  output wire irq_enter_o, irq_return_o
);
  reg [3:0] depth;
  // Return only while a service routine is open
  assign irq_enter_o  = enter_req_i;
  assign irq_return_o = return_req_i && depth != 4'h0;
  // Count of nested service routines
  always @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) depth <= 4'h0;
    else depth <= depth + {3'h0, irq_enter_o} - {3'h0, irq_return_o};
  end
endmodule // core_irq_model

// ---- tb/sfr_page_stack_control_tb_top.sv ----
`timescale 1ns/1ns
module sfr_page_stack_control_tb_top;
  reg        core_clk_i = 1'b0, reset_n_i = 1'b0, enter_req = 1'b0, return_req = 1'b0;
  reg        dir_valid_i = 1'b0, dir_write_i = 1'b0, dir_bit_i = 1'b0;
  reg  [2:0] dir_bit_sel_i = 3'h0;
  reg  [7:0] dir_addr_i = 8'h00, dir_wdata_i = 8'h00, irq_page_i = 8'h00;
  wire [7:0] dir_rdata_o, active_page_o;
  wire       irq_enter_i, irq_return_i, auto_paging_enable_o, dir_hit_o;
  integer    err_total = 0, total_checks = 0, i;
  initial forever #5 core_clk_i = ~core_clk_i;
  core_irq_model core (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .enter_req_i(enter_req),
    .return_req_i(return_req), .irq_enter_o(irq_enter_i), .irq_return_o(irq_return_i));
  sfr_page_stack_control dut (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i),
    .dir_valid_i(dir_valid_i), .dir_write_i(dir_write_i), .dir_bit_i(dir_bit_i),
    .dir_bit_sel_i(dir_bit_sel_i), .dir_addr_i(dir_addr_i), .dir_wdata_i(dir_wdata_i),
    .dir_rdata_o(dir_rdata_o), .dir_hit_o(dir_hit_o), .sfr_sel_o(), .bit_ok_o(),
    .irq_enter_i(irq_enter_i), .irq_page_i(irq_page_i), .irq_return_i(irq_return_i),
    .active_page_o(active_page_o), .auto_paging_enable_o(auto_paging_enable_o));
  task chk(input [63:0] what, input [7:0] exp, input [7:0] got);
    begin
      total_checks = total_checks + 1;
      if (got !== exp) begin
        err_total = err_total + 1;
        $display("BAD %0s expected %h seen %h", what, exp, got);
      end
    end
  endtask
  // One direct access, held for one clock
  task acc(input w, input b, input [7:0] a, input [7:0] d);
    begin
      @(negedge core_clk_i);
      {dir_valid_i, dir_write_i, dir_bit_i, dir_addr_i, dir_wdata_i} = {1'b1, w, b, a, d};
      @(negedge core_clk_i);
      dir_valid_i = 1'b0;
    end
  endtask
  task rd(input [7:0] a, input [7:0] e);
    begin
      acc(1'b0, 1'b0, a, 8'h00);
      chk("rdata", e, dir_rdata_o);
    end
  endtask
  // Decode strobe looked at while a read request stands
  task hit(input [7:0] a, input e);
    begin
      @(negedge core_clk_i);
      {dir_valid_i, dir_write_i, dir_bit_i, dir_addr_i} = {1'b1, 1'b0, 1'b0, a};
      #1;
      chk("hit", {7'h00, e}, {7'h00, dir_hit_o});
      @(negedge core_clk_i);
      dir_valid_i = 1'b0;
    end
  endtask
  // Entry or return strobe, then the page it leaves behind
  task irq(input ent, input [7:0] p, input [7:0] e);
    begin
      @(negedge core_clk_i);
      {enter_req, return_req, irq_page_i} = {ent, !ent, p};
      @(negedge core_clk_i);
      {enter_req, return_req} = 2'b00;
      chk("page", e, active_page_o);
    end
  endtask
  task print_verdict;
    begin
      $display("checks %0d mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0)
        $display("Testbench passed");
      else
        $display("Testbench failed");
      $finish;
    end
  endtask
  // Watchdog on the whole run
  initial begin
    #100000 err_total = err_total + 1;
    print_verdict;
  end
  initial begin
    repeat (2) @(negedge core_clk_i);
    reset_n_i = 1'b1;
    rd(8'ha7, 8'h00);
    rd(8'hcf, 8'h01);
    acc(1'b1, 1'b0, 8'ha7, 8'h0f);
    rd(8'hd3, 8'h0f);
    acc(1'b1, 1'b0, 8'hcf, 8'h11);
    rd(8'hd3, 8'h00);
    $display("test reset done");
    acc(1'b1, 1'b0, 8'ha7, 8'h01);
    for (i = 2; i < 6; i = i + 1) irq(1'b1, 8'h0f - i[7:0], 8'h0f - i[7:0]);
    irq(1'b1, 8'h0f, 8'h0f);
    acc(1'b1, 1'b0, 8'ha7, 8'h05);
    acc(1'b1, 1'b0, 8'ha7, 8'h0f);
    for (i = 0; i < 5; i = i + 1) begin
      acc(1'b1, 1'b0, 8'hcf, {1'b0, i[2:0], 4'h1});
      rd(8'hd3, (i == 0) ? 8'h0f : 8'h09 + i[7:0]);
    end
    for (i = 1; i < 5; i = i + 1) irq(1'b0, 8'h00, 8'h09 + i[7:0]);
    $display("test stack done");
    acc(1'b1, 1'b0, 8'hcf, 8'h00);
    rd(8'hcf, 8'h00);
    chk("enable", 8'h00, {7'h00, auto_paging_enable_o});
    irq(1'b1, 8'h0f, 8'h0d);
    irq(1'b0, 8'h00, 8'h0d);
    acc(1'b1, 1'b0, 8'hcf, 8'h01);
    chk("enable", 8'h01, {7'h00, auto_paging_enable_o});
    // Entry straight into return restores the page in use
    @(negedge core_clk_i);
    {enter_req, irq_page_i} = {1'b1, 8'h00};
    @(negedge core_clk_i);
    {enter_req, return_req} = 2'b01;
    chk("page", 8'h00, active_page_o);
    @(negedge core_clk_i);
    return_req = 1'b0;
    chk("page", 8'h0d, active_page_o);
    $display("test auto off done");
    dir_bit_sel_i = 3'h2;
    acc(1'b1, 1'b1, 8'ha7, 8'h01);
    chk("page", 8'h0d, active_page_o);
    acc(1'b1, 1'b0, 8'h27, 8'h33);
    chk("page", 8'h0d, active_page_o);
    rd(8'h81, 8'h00);
    rd(8'hd3, 8'h00);
    hit(8'hd3, 1'b0);
    hit(8'h81, 1'b0);
    hit(8'hcf, 1'b1);
    acc(1'b1, 1'b0, 8'ha7, 8'hff);
    rd(8'ha7, 8'hff);
    hit(8'ha7, 1'b1);
    $display("test decode done");
    @(negedge core_clk_i);
    reset_n_i = 1'b0;
    @(negedge core_clk_i);
    reset_n_i = 1'b1;
    rd(8'ha7, 8'h00);
    rd(8'hcf, 8'h01);
    $display("test reset again done");
    print_verdict;
  end
endmodule // sfr_page_stack_control_tb_top
